// ---- processor_throttle_pwm.sv ----
// Purpose: software forced processor throttle pwm with regulator hot pass-through
// Assumes: single ahb-lite slave, zero wait states, inputs synchronous to hclk
// Notes:   throttle outputs are active low levels from flip-flops
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Contract
// RULE1: control bits 3:0 select the forced throttle duty.
// RULE2: each forced period is 80 ticks of a 22.5 kHz internal clock.
// RULE3: asserted width is (select+1)*5 ticks, 5 up to full 80.
// RULE4: force bits 6 and 7 drive cpu1/cpu2 throttle with the selected duty.
// RULE5: block bits 4 and 5 stop regulator hot from asserting that throttle.
// RULE6: with pins tied, both throttle outputs follow either force bit.
// RULE7: control register resets to zero: no forcing, pass-through on.
module processor_throttle_pwm #(
  parameter int TICK_CYCLES  = throttle_pkg::TICK_CYCLES,
  parameter int PERIOD_TICKS = throttle_pkg::PERIOD_TICKS,
  parameter int STEP_TICKS   = throttle_pkg::STEP_TICKS
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        cpu1_regulator_hot_n,
  input  wire logic        cpu2_regulator_hot_n,
  output logic             cpu1_throttle_n,
  output logic             cpu2_throttle_n
);

  // ==========================================================
  // parameter checks
  initial begin
    if (TICK_CYCLES < 2 || PERIOD_TICKS < 1 || PERIOD_TICKS > 255 ||
        STEP_TICKS * 16 != PERIOD_TICKS) begin
      $error("processor_throttle_pwm: unsupported parameters");
    end
  end

  // ==========================================================
  // registers and state
  logic [7:0]  ctrl_q;
  logic        tied_q;
  logic        wr_pend_q;
  logic [9:0]  wr_addr_q;
  logic [13:0] tick_cnt_q;
  logic        tick;
  logic [7:0]  phase_q;
  logic        pwm_on_q;
  logic [7:0]  on_ticks;
  logic        force_a;
  logic        force_b;
  logic [1:0]  hot_ch;
  logic [1:0]  force_ch;
  logic [1:0]  block_ch;
  logic [1:0]  vr_hot_n;
  logic [1:0]  throttle_n_q;
  logic        addr_ok;

  initial begin
    if (TICK_CYCLES > 16383) begin
      $error("processor_throttle_pwm: tick divider too wide");
    end
  end

  // ==========================================================
  // ahb-lite slave
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ok   = hsel && hready && htrans[1] && (hsize == throttle_pkg::HSIZE_WORD);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 10'h000;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      wr_addr_q <= haddr[9:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= throttle_pkg::RST_THROTTLE_CONTROL; // RULE7
    end else if (wr_pend_q && wr_addr_q == throttle_pkg::ADDR_THROTTLE_CONTROL) begin
      ctrl_q <= hwdata[7:0]; // RULE1
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tied_q <= throttle_pkg::RST_PINS_TIED;
    end else if (wr_pend_q && wr_addr_q == throttle_pkg::ADDR_THROTTLE_CONFIG) begin
      tied_q <= hwdata[throttle_pkg::CFG_TIED];
    end
  end

  // read data is captured in the address phase; unmapped reads return zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      if (haddr[9:0] == throttle_pkg::ADDR_THROTTLE_CONTROL) begin
        hrdata <= {24'h00_0000, ctrl_q};
      end else if (haddr[9:0] == throttle_pkg::ADDR_THROTTLE_CONFIG) begin
        hrdata <= {28'h000_0000, pwm_on_q, ~cpu2_throttle_n, ~cpu1_throttle_n, tied_q};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // 22.5 kHz tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_q <= 14'h0000;
    end else if (tick) begin
      tick_cnt_q <= 14'h0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 14'h0001;
    end
  end
  assign tick = (tick_cnt_q == 14'(TICK_CYCLES - 1));

  // ==========================================================
  // pwm period and duty
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= 8'h00;
    end else if (tick) begin
      if (phase_q == 8'(PERIOD_TICKS - 1)) begin
        phase_q <= 8'h00; // RULE2
      end else begin
        phase_q <= phase_q + 8'h01;
      end
    end
  end

  assign on_ticks = 8'((ctrl_q[throttle_pkg::DUTY_MSB:throttle_pkg::DUTY_LSB] + 8'h01) * STEP_TICKS); // RULE3

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwm_on_q <= 1'b0;
    end else begin
      pwm_on_q <= (phase_q < on_ticks); // RULE3
    end
  end

  // ==========================================================
  // throttle outputs
  assign force_a = ctrl_q[throttle_pkg::FORCE1] || (tied_q && ctrl_q[throttle_pkg::FORCE2]); // RULE6
  assign force_b = ctrl_q[throttle_pkg::FORCE2] || (tied_q && ctrl_q[throttle_pkg::FORCE1]); // RULE6
  assign force_ch = {force_b, force_a};
  assign block_ch = {ctrl_q[throttle_pkg::VR_BLOCK2], ctrl_q[throttle_pkg::VR_BLOCK1]};
  assign vr_hot_n = {cpu2_regulator_hot_n, cpu1_regulator_hot_n};

  // one output stage per processor
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    assign hot_ch[ch] = !vr_hot_n[ch] && !block_ch[ch]; // RULE5

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        throttle_n_q[ch] <= 1'b1;
      end else begin
        throttle_n_q[ch] <= !((force_ch[ch] && pwm_on_q) || hot_ch[ch]); // RULE4
      end
    end
  end

  assign cpu1_throttle_n = throttle_n_q[0];
  assign cpu2_throttle_n = throttle_n_q[1];

  // ==========================================================
  // assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  duty_write_a: assert property (wr_pend_q && wr_addr_q == throttle_pkg::ADDR_THROTTLE_CONTROL
    |=> ctrl_q[3:0] == $past(hwdata[3:0])) else $error("duty select not written"); // RULE1
  period_wrap_a: assert property (tick && phase_q == 8'(PERIOD_TICKS - 1) |=> phase_q == 8'h00)
    else $error("period did not wrap at 80 ticks"); // RULE2
  phase_range_a: assert property (phase_q < 8'(PERIOD_TICKS))
    else $error("phase out of range"); // RULE2
  first_tick_on_a: assert property (phase_q == 8'h00 |=> pwm_on_q)
    else $error("pwm not asserted at period start"); // RULE3
  duty_edge_a: assert property (phase_q == 8'h05 && ctrl_q[3:0] == 4'h0 |=> !pwm_on_q)
    else $error("minimum duty exceeded 5 ticks"); // RULE3
  force_drive_a: assert property (ctrl_q[throttle_pkg::FORCE1] && pwm_on_q |=> !cpu1_throttle_n)
    else $error("forced throttle not driven"); // RULE4
  vr_block_a: assert property (ctrl_q[5:4] == 2'b11 && !force_a && !force_b
    ##1 ctrl_q[5:4] == 2'b11 |-> cpu1_throttle_n && cpu2_throttle_n)
    else $error("blocked regulator hot asserted throttle"); // RULE5
  pins_tied_a: assert property (tied_q && ctrl_q[throttle_pkg::FORCE2] && pwm_on_q |=> !cpu1_throttle_n)
    else $error("tied pins not driven together"); // RULE6
  reset_zero_a: assert property (@(posedge hclk) $rose(hresetn) |-> ctrl_q == 8'h00)
    else $error("control not zero after reset"); // RULE7

  // ==========================================================
  // bus side checks
  bus_okay_a: assert property (
    hreadyout && !hresp)
    else $error("slave not ready or not okay");
  read_ctrl_a: assert property (addr_ok && !hwrite && haddr[9:0] == throttle_pkg::ADDR_THROTTLE_CONTROL // RULE1
    |=> hrdata == {24'h00_0000, $past(ctrl_q)})
    else $error("control read data wrong");
  ctrl_full_a: assert property (wr_pend_q && wr_addr_q == throttle_pkg::ADDR_THROTTLE_CONTROL // RULE1
    |=> ctrl_q == $past(hwdata[7:0]))
    else $error("control byte not written");
  read_cfg_a: assert property (addr_ok && !hwrite && haddr[9:0] == throttle_pkg::ADDR_THROTTLE_CONFIG // RULE6
    |=> hrdata[0] == $past(tied_q))
    else $error("tied bit read wrong");
  cfg_write_a: assert property (wr_pend_q && wr_addr_q == throttle_pkg::ADDR_THROTTLE_CONFIG // RULE6
    |=> tied_q == $past(hwdata[0]))
    else $error("tied bit not written");
  read_hold_a: assert property (
    !(addr_ok && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");
  sized_write_a: assert property (hsel && hready && htrans[1] && hwrite && hsize != throttle_pkg::HSIZE_WORD
    |=> !wr_pend_q)
    else $error("non-word write accepted");

  // ==========================================================
  // tick and period checks
  tick_range_a: assert property ( // RULE2
    tick_cnt_q < 14'(TICK_CYCLES))
    else $error("tick divider out of range");
  tick_gap_a: assert property ( // RULE2
    tick |=> !tick)
    else $error("ticks back to back");
  phase_hold_a: assert property ( // RULE2
    !tick |=> phase_q == $past(phase_q))
    else $error("phase moved without a tick");
  phase_step_a: assert property (tick && phase_q != 8'(PERIOD_TICKS - 1) // RULE2
    |=> phase_q == $past(phase_q) + 8'h01)
    else $error("phase did not step on tick");

  // ==========================================================
  // duty checks
  duty_full_a: assert property ( // RULE3
    ctrl_q[3:0] == 4'hf |=> pwm_on_q)
    else $error("full duty not fully asserted");
  duty_stop_a: assert property ( // RULE3
    phase_q == 8'((ctrl_q[3:0] + 5'h01) * STEP_TICKS) |=> !pwm_on_q)
    else $error("asserted width too long");
  duty_run_a: assert property ( // RULE3
    phase_q < 8'(STEP_TICKS) |=> pwm_on_q)
    else $error("first step not asserted");

  // ==========================================================
  // output checks
  force_drive2_a: assert property (ctrl_q[throttle_pkg::FORCE2] && pwm_on_q // RULE4
    |=> !cpu2_throttle_n)
    else $error("forced cpu2 throttle not driven");
  force_off1_a: assert property (!pwm_on_q && cpu1_regulator_hot_n // RULE4
    |=> cpu1_throttle_n)
    else $error("cpu1 throttle asserted in off phase");
  force_off2_a: assert property (!pwm_on_q && cpu2_regulator_hot_n // RULE4
    |=> cpu2_throttle_n)
    else $error("cpu2 throttle asserted in off phase");
  hot_pass1_a: assert property (!cpu1_regulator_hot_n && !ctrl_q[throttle_pkg::VR_BLOCK1] // RULE5
    |=> !cpu1_throttle_n)
    else $error("regulator hot not passed to cpu1");
  hot_pass2_a: assert property (!cpu2_regulator_hot_n && !ctrl_q[throttle_pkg::VR_BLOCK2] // RULE5
    |=> !cpu2_throttle_n)
    else $error("regulator hot not passed to cpu2");
  hot_block1_a: assert property (!cpu1_regulator_hot_n && ctrl_q[throttle_pkg::VR_BLOCK1] && !pwm_on_q // RULE5
    |=> cpu1_throttle_n)
    else $error("blocked regulator hot reached cpu1");
  hot_block2_a: assert property (!cpu2_regulator_hot_n && ctrl_q[throttle_pkg::VR_BLOCK2] && !pwm_on_q // RULE5
    |=> cpu2_throttle_n)
    else $error("blocked regulator hot reached cpu2");
  pins_tied2_a: assert property (tied_q && ctrl_q[throttle_pkg::FORCE1] && pwm_on_q // RULE6
    |=> !cpu2_throttle_n)
    else $error("tied pins not driven together on cpu2");
  untied_a: assert property (!tied_q && !ctrl_q[throttle_pkg::FORCE2] && cpu2_regulator_hot_n // RULE6
    |=> cpu2_throttle_n)
    else $error("untied cpu2 throttle driven by cpu1 force");

  force_cov_c:  cover property (ctrl_q[throttle_pkg::FORCE1] ##1 !cpu1_throttle_n);
  tied_cov_c:   cover property (tied_q && ctrl_q[7:6] == 2'b10 ##1 !cpu1_throttle_n);
  hot_cov_c:    cover property (!cpu2_regulator_hot_n ##1 !cpu2_throttle_n);
  full_duty_c:  cover property (ctrl_q[3:0] == 4'hf && phase_q == 8'(PERIOD_TICKS - 1) ##1 pwm_on_q);
  untied_c:     cover property (!tied_q && ctrl_q[7:6] == 2'b01 ##1 !cpu1_throttle_n && cpu2_throttle_n);

endmodule // processor_throttle_pwm
`default_nettype wire

// ---- throttle_pkg.sv ----
// Purpose: constants for the processor throttle pwm block
// Assumes: 32-bit ahb-lite register access, 200 MHz hclk
// Notes:   offsets are register indices; byte address is four times the index
`default_nettype none
package throttle_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0]  IDX_THROTTLE_CONTROL = 8'hc6;
  localparam logic [7:0]  IDX_THROTTLE_CONFIG  = 8'hc8;
  localparam logic [9:0]  ADDR_THROTTLE_CONTROL = {IDX_THROTTLE_CONTROL, 2'b00};
  localparam logic [9:0]  ADDR_THROTTLE_CONFIG  = {IDX_THROTTLE_CONFIG, 2'b00};
  localparam logic [7:0]  RST_THROTTLE_CONTROL = 8'h00;
  localparam logic        RST_PINS_TIED        = 1'b0;
  // ==========================================================
  // control fields
  localparam int DUTY_LSB     = 0;
  localparam int DUTY_MSB     = 3;
  localparam int VR_BLOCK1    = 4;
  localparam int VR_BLOCK2    = 5;
  localparam int FORCE1       = 6;
  localparam int FORCE2       = 7;
  // config fields
  localparam int CFG_TIED     = 0;
  localparam int CFG_OUT1     = 1;
  localparam int CFG_OUT2     = 2;
  localparam int CFG_PWM      = 3;
  // ==========================================================
  // timing
  localparam int CLK_HZ        = 200000000;
  localparam int TICK_HZ       = 22500;
  localparam int TICK_CYCLES   = CLK_HZ / TICK_HZ;
  localparam int PERIOD_TICKS  = 80;
  localparam int STEP_TICKS    = 5;
  // ==========================================================
  // ahb
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] HSIZE_WORD    = 3'b010;
endpackage
`default_nettype wire

// ---- regulator_hot_model.sv ----
// Purpose: far side regulator hot drivers for two processors
// Assumes: levels change just after a rising hclk edge
// Notes:   hot_req bit high asks for an asserted, active-low level
`timescale 1ns/1ps
`default_nettype none
module regulator_hot_model (
  input  wire logic       hclk,
  input  wire logic [1:0] hot_req,
  output logic            cpu1_regulator_hot_n,
  output logic            cpu2_regulator_hot_n
);
  // ==========================================================
  // drivers
  initial begin
    cpu1_regulator_hot_n = 1'b1;
    cpu2_regulator_hot_n = 1'b1;
  end
  always @(posedge hclk) begin
    cpu1_regulator_hot_n <= ~hot_req[0];
    cpu2_regulator_hot_n <= ~hot_req[1];
  end
endmodule // regulator_hot_model
`default_nettype wire

// ---- processor_throttle_pwm_tb.sv ----
// Purpose: self-checking bench for the processor throttle pwm block
// Assumes: tick shortened to 4 hclk cycles
// Notes:   duty checked by counting low cycles over one whole period
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; $display("FAIL %s exp %h got %h", n, e, g); end end
module processor_throttle_pwm_tb;
  localparam int          TC   = 4;
  localparam int          PER  = throttle_pkg::PERIOD_TICKS * TC;
  localparam logic [31:0] CTRL = 32'(throttle_pkg::ADDR_THROTTLE_CONTROL);
  localparam logic [31:0] CFG  = 32'(throttle_pkg::ADDR_THROTTLE_CONFIG);
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = throttle_pkg::HSIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic        hreadyout, hresp, hot1_n, hot2_n, thr1_n, thr2_n, tied, on1, on2;
  logic [1:0]  hot_req = 2'h0;
  logic [1:0]  f;
  logic [3:0]  sel;
  logic [31:0] seed = 32'hcc27;
  int          num_errors = 0;
  int          total_checks = 0;
  int          n1, n2;
  // ==========================================================
  // design and far side
  processor_throttle_pwm #(.TICK_CYCLES(TC)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cpu1_regulator_hot_n(hot1_n), .cpu2_regulator_hot_n(hot2_n),
    .cpu1_throttle_n(thr1_n), .cpu2_throttle_n(thr2_n));
  regulator_hot_model model (.hclk(hclk), .hot_req(hot_req), .cpu1_regulator_hot_n(hot1_n),
    .cpu2_regulator_hot_n(hot2_n));
  initial begin
    forever #2.5 hclk = ~hclk;
  end
  // ==========================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic int exp_low(input logic on, input logic [3:0] s);
    return on ? (int'(s) + 1) * throttle_pkg::STEP_TICKS * TC : 0;
  endfunction
  task automatic finish_test();
    if (num_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wait_ready();
    for (int i = 0; i < 16; i++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) return;
    end
    num_errors++;
    finish_test();
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= throttle_pkg::HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic measure();
    n1 = 0;
    n2 = 0;
    repeat (2) @(posedge hclk);
    repeat (PER) begin
      @(negedge hclk);
      n1 += int'(thr1_n === 1'b0);
      n2 += int'(thr2_n === 1'b0);
    end
    @(posedge hclk);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, CTRL, 32'h0);
    `CHK("ctrl_reset", 32'h0, rd)
    `CHK("idle_throttle", 2'b11, {thr2_n, thr1_n})
    bus(1'b0, 32'h3fc, 32'h0);
    `CHK("unmapped_read", 32'h0, rd)
    for (int k = 0; k < 8; k++) begin
      seed = xs(seed);
      sel = (k == 0) ? 4'h0 : (k == 1) ? 4'hf : seed[3:0];
      f = (k == 0) ? 2'b11 : (k == 1) ? 2'b01 : seed[7:6];
      tied = (k == 1) ? 1'b1 : seed[8];
      on1 = f[0] | (tied & f[1]);
      on2 = f[1] | (tied & f[0]);
      bus(1'b1, CFG, {31'h0, tied});
      bus(1'b0, CFG, 32'h0);
      `CHK("tied_read", 32'(tied), rd & 32'h1)
      bus(1'b1, CTRL, {24'h0, f, seed[5:4], sel});
      bus(1'b0, CTRL, 32'h0);
      `CHK("ctrl_read", {24'h0, f, seed[5:4], sel}, rd)
      measure();
      `CHK("cpu1_low", exp_low(on1, sel), n1)
      `CHK("cpu2_low", exp_low(on2, sel), n2)
    end
    bus(1'b1, CFG, 32'h0);
    for (int b = 0; b < 4; b++) begin
      bus(1'b1, CTRL, {26'h0, 2'(b), 4'h0});
      hot_req <= 2'b11;
      repeat (4) @(negedge hclk);
      `CHK("hot_pass", 2'(b), {thr2_n, thr1_n})
      @(posedge hclk);
      hot_req <= 2'b00;
      repeat (3) @(posedge hclk);
    end
    `CHK("bus_okay", 2'b01, {hresp, hreadyout})
    finish_test();
  end
endmodule // processor_throttle_pwm_tb
`default_nettype wire
